/* hdl/spfc_port.sv */
// Local flow control for one asynchronous user port of a packet comm unit.
// Assumes the character receiver and transmitter run on i_mclk; only the
// RTS pin comes from outside and is synchronised here.
`include "spfc_consts.svh"

module spfc_port #(
    parameter int SESS = `SPFC_SESS_DEF,
    parameter int SW   = (SESS > 1) ? $clog2(SESS) : 1
) (
    input  wire logic                    i_mclk,
    input  wire logic                    i_rst_n,
    // Configuration command.
    input  wire logic                    i_cfg_wr,
    input  wire logic [`SPFC_MODE_W-1:0] i_cfg_mode,
    input  wire logic [`SPFC_CHAR_W-1:0] i_cfg_resume,
    input  wire logic [`SPFC_CHAR_W-1:0] i_cfg_pause,
    // Session commands.
    input  wire logic                    i_suspend,
    input  wire logic [SESS-1:0]         i_suspend_mask,
    input  wire logic                    i_switch,
    input  wire logic [SW-1:0]           i_switch_sess,
    // Resource state.
    input  wire logic                    i_buf_low,
    input  wire logic [SESS-1:0]         i_remote_fc,
    // Handshake pins.
    input  wire logic                    i_rts,
    output logic                         o_cts,
    // Characters received from the user device.
    input  wire logic                    i_rx_valid,
    input  wire logic [`SPFC_CHAR_W-1:0] i_rx_data,
    output logic                         o_fwd_valid,
    output logic [`SPFC_CHAR_W-1:0]      o_fwd_data,
    // Characters from the sessions toward the user device.
    input  wire logic                    i_tx_valid,
    input  wire logic [`SPFC_CHAR_W-1:0] i_tx_data,
    output logic                         o_tx_ready,
    // Character transmitter toward the user device.
    output logic                         o_ser_valid,
    output logic [`SPFC_CHAR_W-1:0]      o_ser_data,
    input  wire logic                    i_ser_ready,
    // Status.
    output logic [`SPFC_MODE_W-1:0]      o_mode,
    output logic                         o_out_halt,
    output logic [SESS-1:0]              o_sess_throttle,
    output logic [SESS-1:0]              o_sess_out_en,
    output logic [SW-1:0]                o_cur_sess
);

    // ******************************************************************
    // Declarations
    // ******************************************************************

    spfc_pkg::spfc_mode_t     mode_r;
    spfc_pkg::spfc_mode_t     mode_nxt;
    logic [`SPFC_CHAR_W-1:0]  resume_r;
    logic [`SPFC_CHAR_W-1:0]  resume_nxt;
    logic [`SPFC_CHAR_W-1:0]  pause_r;
    logic [`SPFC_CHAR_W-1:0]  pause_nxt;
    logic                     user_paused_r;
    logic                     user_paused_nxt;
    logic                     sent_pause_r;
    logic                     sent_pause_nxt;
    logic                     pend_r;
    logic                     pend_nxt;
    logic                     pend_is_pause_r;
    logic                     pend_is_pause_nxt;
    logic                     fwd_valid_r;
    logic                     fwd_valid_nxt;
    logic [`SPFC_CHAR_W-1:0]  fwd_data_r;
    logic [`SPFC_CHAR_W-1:0]  fwd_data_nxt;
    logic                     ser_valid_r;
    logic                     ser_valid_nxt;
    logic [`SPFC_CHAR_W-1:0]  ser_data_r;
    logic [`SPFC_CHAR_W-1:0]  ser_data_nxt;
    logic                     tx_ready_r;
    logic                     tx_ready_nxt;
    logic                     cts_r;
    logic                     cts_nxt;
    logic                     halt_r;
    logic                     halt_nxt;
    logic [SESS-1:0]          throttle_r;
    logic [SESS-1:0]          throttle_nxt;
    logic [SESS-1:0]          out_en_r;
    logic [SESS-1:0]          out_en_nxt;
    logic                     rts_s;
    logic [SW-1:0]            cur_sess;
    logic [SESS-1:0]          suspended;
    logic                     blocked;
    logic                     tx_take;
    logic                     slot_free;

    // ******************************************************************
    // Submodules
    // ******************************************************************

    // RTS idles high so a port with nothing attached is not halted.
    spfc_sync2 #(
        .RST_VAL (1'b1)
    ) u_rts_sync (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_async (i_rts),
        .o_sync  (rts_s)
    );

    // Session bookkeeping for suspend and switch commands.
    spfc_sess_flags #(
        .SESS (SESS),
        .SW   (SW)
    ) u_sess (
        .i_mclk         (i_mclk),
        .i_rst_n        (i_rst_n),
        .i_suspend      (i_suspend),
        .i_suspend_mask (i_suspend_mask),
        .i_switch       (i_switch),
        .i_switch_sess  (i_switch_sess),
        .o_cur_sess     (cur_sess),
        .o_suspended    (suspended)
    );

    // ******************************************************************
    // Input blocking condition
    // ******************************************************************

    // Input from the user is blocked on local buffer shortage or when the
    // far end throttles the current session; the remote flag is not ours
    // to clear, so a freshly switched session may still be held here.
    assign blocked = i_buf_low | i_remote_fc[cur_sess];

    // A character is taken from the sessions only when the ready that the
    // source saw was high; ready is registered, costing one idle cycle per
    // character, which is far faster than any serial rate anyway.
    assign tx_take   = i_tx_valid & tx_ready_r;
    assign slot_free = ~ser_valid_r | i_ser_ready;

    // ******************************************************************
    // Next state
    // ******************************************************************

    // Configuration, pause bookkeeping and both data paths; status is in the next block.
    always_comb
    begin
        mode_nxt          = mode_r;
        resume_nxt        = resume_r;
        pause_nxt         = pause_r;
        user_paused_nxt   = user_paused_r;
        sent_pause_nxt    = sent_pause_r;
        pend_nxt          = pend_r;
        pend_is_pause_nxt = pend_is_pause_r;
        fwd_valid_nxt     = 1'b0;
        fwd_data_nxt      = fwd_data_r;
        ser_valid_nxt     = ser_valid_r;
        ser_data_nxt      = ser_data_r;

        // Mode and codes are per port; one code pair serves both ways.
        if (i_cfg_wr)
        begin
            mode_nxt   = spfc_pkg::spfc_mode_t'(i_cfg_mode);
            resume_nxt = i_cfg_resume;
            pause_nxt  = i_cfg_pause;
        end

        // Received characters. Control codes act only in software mode;
        // in the other modes every character passes untouched.
        if (i_rx_valid)
        begin
            fwd_data_nxt = i_rx_data;
            if (mode_r != spfc_pkg::SPFC_MODE_SW)
            begin
                fwd_valid_nxt = 1'b1;
            end
            else if (i_rx_data == pause_r)
            begin
                user_paused_nxt = 1'b1;
            end
            else if ((i_rx_data == resume_r) && user_paused_r)
            begin
                user_paused_nxt = 1'b0;
            end
            else
            begin
                // A stray resume falls through here as ordinary data.
                fwd_valid_nxt = ~sent_pause_r;
            end
        end

        // Software mode: announce a change of the blocking condition.
        // A newer change cancels one still waiting, so a pause and its
        // resume never both go out when the condition merely flickers.
        if (mode_r == spfc_pkg::SPFC_MODE_SW)
        begin
            if (blocked && !sent_pause_r)
            begin
                sent_pause_nxt    = 1'b1;
                pend_nxt          = ~(pend_r & ~pend_is_pause_r);
                pend_is_pause_nxt = 1'b1;
            end
            else if (!blocked && sent_pause_r)
            begin
                sent_pause_nxt    = 1'b0;
                pend_nxt          = ~(pend_r & pend_is_pause_r);
                pend_is_pause_nxt = 1'b0;
            end
        end
        else
        begin
            // Leaving software mode drops all character flow state.
            user_paused_nxt = 1'b0;
            sent_pause_nxt  = 1'b0;
            pend_nxt        = 1'b0;
        end

        // Transmit slot: control characters go ahead of session data and
        // are not held back by a user pause.
        if (slot_free)
        begin
            ser_valid_nxt = 1'b0;
            if (pend_r && pend_nxt)  // A code cancelled in this cycle is never sent.
            begin
                ser_valid_nxt = 1'b1;
                ser_data_nxt  = pend_is_pause_r ? pause_r : resume_r;
                pend_nxt      = 1'b0;
            end
            else if (tx_take)
            begin
                ser_valid_nxt = 1'b1;
                ser_data_nxt  = i_tx_data;
            end
        end
    end

    // Status and flow outputs follow the state just computed.
    always_comb
    begin
        // Output halts on a dropped RTS in handshake mode or a user pause
        // in software mode; RTS means nothing in the other modes.
        halt_nxt = ((mode_nxt == spfc_pkg::SPFC_MODE_HW) & ~rts_s)
                 | ((mode_nxt == spfc_pkg::SPFC_MODE_SW) & user_paused_nxt);

        // CTS follows the blocking condition only in handshake mode.
        if (mode_nxt == spfc_pkg::SPFC_MODE_HW)
        begin
            cts_nxt = ~blocked;
        end
        else
        begin
            cts_nxt = 1'b1;
        end

        // A halt throttles the current session toward the network;
        // suspended inactive sessions are throttled and may not output.
        for (int i = 0; i < SESS; i++)
        begin
            throttle_nxt[i] = suspended[i] | ((SW'(i) == cur_sess) & halt_nxt);
            out_en_nxt[i]   = ~suspended[i] & ~halt_nxt;
        end

        // Ready only when the slot will be empty next cycle and no control
        // character waits, so an accepted character always has room.
        tx_ready_nxt = ~halt_nxt & ~pend_nxt & ~ser_valid_nxt & ~tx_take;
    end

    // ******************************************************************
    // Registers
    // ******************************************************************

    // All state and every output of the port except the session state kept in u_sess and the RTS synchroniser stages.
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            mode_r          <= spfc_pkg::SPFC_MODE_NONE;
            resume_r        <= `SPFC_RESUME_DEF;
            pause_r         <= `SPFC_PAUSE_DEF;
            user_paused_r   <= 1'b0;
            sent_pause_r    <= 1'b0;
            pend_r          <= 1'b0;
            pend_is_pause_r <= 1'b0;
            fwd_valid_r     <= 1'b0;
            fwd_data_r      <= '0;
            ser_valid_r     <= 1'b0;
            ser_data_r      <= '0;
            tx_ready_r      <= 1'b0;
            cts_r           <= 1'b1;
            halt_r          <= 1'b0;
            throttle_r      <= '0;
            out_en_r        <= '0;
        end
        else
        begin
            mode_r          <= mode_nxt;
            resume_r        <= resume_nxt;
            pause_r         <= pause_nxt;
            user_paused_r   <= user_paused_nxt;
            sent_pause_r    <= sent_pause_nxt;
            pend_r          <= pend_nxt;
            pend_is_pause_r <= pend_is_pause_nxt;
            fwd_valid_r     <= fwd_valid_nxt;
            fwd_data_r      <= fwd_data_nxt;
            ser_valid_r     <= ser_valid_nxt;
            ser_data_r      <= ser_data_nxt;
            tx_ready_r      <= tx_ready_nxt;
            cts_r           <= cts_nxt;
            halt_r          <= halt_nxt;
            throttle_r      <= throttle_nxt;
            out_en_r        <= out_en_nxt;
        end
    end

    // ******************************************************************
    // Outputs
    // ******************************************************************

    assign o_cts           = cts_r;
    assign o_fwd_valid     = fwd_valid_r;
    assign o_fwd_data      = fwd_data_r;
    assign o_tx_ready      = tx_ready_r;
    assign o_ser_valid     = ser_valid_r;
    assign o_ser_data      = ser_data_r;
    assign o_mode          = mode_r;
    assign o_out_halt      = halt_r;
    assign o_sess_throttle = throttle_r;
    assign o_sess_out_en   = out_en_r;
    assign o_cur_sess      = cur_sess;

endmodule

/* hdl/spfc_consts.svh */
// Constants for the serial port flow control block: default codes and widths.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SPFC_CONSTS_SVH
`define SPFC_CONSTS_SVH

`define SPFC_CHAR_W      8
`define SPFC_RESUME_DEF  8'h11
`define SPFC_PAUSE_DEF   8'h13
`define SPFC_SESS_DEF    4
`define SPFC_MODE_W      2

`endif

/* hdl/spfc_pkg.sv */
// Types shared by the serial port flow control modules.
// Assumes spfc_consts.svh is on the include path.
`include "spfc_consts.svh"

package spfc_pkg;

    // Flow control mode of one port, as written by the configuration command.
    typedef enum logic [`SPFC_MODE_W-1:0]
    {
        SPFC_MODE_NONE,
        SPFC_MODE_HW,
        SPFC_MODE_SW
    } spfc_mode_t;

endpackage

/* hdl/spfc_sync2.sv */
// Two flip-flop synchroniser for one level from a pin.
// Assumes a single clock and a synchronous active low reset.
module spfc_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    input  wire logic i_async,
    output logic      o_sync
);

    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;

    // The first stage feeds only the second stage.
    always_comb
    begin
        meta_nxt = i_async;
        sync_nxt = meta_r;
    end

    // Registers take the reset constant while reset is low.
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign o_sync = sync_r;

endmodule

/* hdl/spfc_sess_flags.sv */
// Current session index and per-session local suspend flags of one port.
// Assumes suspend and switch commands arrive as one-cycle pulses on i_mclk.
`include "spfc_consts.svh"

module spfc_sess_flags #(
    parameter int SESS = `SPFC_SESS_DEF,
    parameter int SW   = (SESS > 1) ? $clog2(SESS) : 1
) (
    input  wire logic            i_mclk,
    input  wire logic            i_rst_n,
    input  wire logic            i_suspend,
    input  wire logic [SESS-1:0] i_suspend_mask,
    input  wire logic            i_switch,
    input  wire logic [SW-1:0]   i_switch_sess,
    output logic      [SW-1:0]   o_cur_sess,
    output logic      [SESS-1:0] o_suspended
);

    logic [SW-1:0]   cur_r;
    logic [SW-1:0]   cur_nxt;
    logic [SESS-1:0] susp_r;
    logic [SESS-1:0] susp_nxt;

    // Suspend touches only inactive sessions; a switch clears the new
    // current session's flag, so it can output unless the port is halted.
    always_comb
    begin
        cur_nxt  = cur_r;
        susp_nxt = susp_r;
        if (i_suspend)
        begin
            for (int i = 0; i < SESS; i++)
            begin
                if (i_suspend_mask[i] && (SW'(i) != cur_r))
                begin
                    susp_nxt[i] = 1'b1;
                end
            end
        end
        if (i_switch && (int'(i_switch_sess) < SESS))
        begin
            cur_nxt                = i_switch_sess;
            susp_nxt[i_switch_sess] = 1'b0;
        end
    end

    // State registers.
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            cur_r  <= '0;
            susp_r <= '0;
        end
        else
        begin
            cur_r  <= cur_nxt;
            susp_r <= susp_nxt;
        end
    end

    assign o_cur_sess  = cur_r;
    assign o_suspended = susp_r;

endmodule

/* tb/spfc_port_props.sv */
// Concurrent checks on the ports of spfc_port, bound into every instance.
// Assumes one clock domain and the synchronous active low reset.
`include "spfc_consts.svh"

module spfc_port_props #(
    parameter int SESS = 4,
    parameter int SW   = 2
) (
    input wire logic                    i_mclk,
    input wire logic                    i_rst_n,
    input wire logic                    i_cfg_wr,
    input wire logic [`SPFC_CHAR_W-1:0] i_cfg_pause,
    input wire logic                    i_suspend,
    input wire logic [SESS-1:0]         i_suspend_mask,
    input wire logic                    i_switch,
    input wire logic [SW-1:0]           i_switch_sess,
    input wire logic                    i_buf_low,
    input wire logic [SESS-1:0]         i_remote_fc,
    input wire logic                    i_rx_valid,
    input wire logic [`SPFC_CHAR_W-1:0] i_rx_data,
    input wire logic                    o_fwd_valid,
    input wire logic [`SPFC_CHAR_W-1:0] o_fwd_data,
    input wire logic                    o_tx_ready,
    input wire logic                    o_cts,
    input wire logic [`SPFC_MODE_W-1:0] o_mode,
    input wire logic                    o_out_halt,
    input wire logic [SESS-1:0]         o_sess_throttle,
    input wire logic [SESS-1:0]         o_sess_out_en,
    input wire logic [SW-1:0]           o_cur_sess
);
    timeunit 1ns;
    timeprecision 100ps;
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    logic [`SPFC_CHAR_W-1:0] pause_r;
    logic [`SPFC_CHAR_W-1:0] pause_nxt;
    // Shadow of the pause code, since the port only shows it on a write.
    always_comb pause_nxt = i_cfg_wr ? i_cfg_pause : pause_r;
    always_ff @(posedge i_mclk) pause_r <= !i_rst_n ? `SPFC_PAUSE_DEF : pause_nxt;

    cts_held_a: assert property ($past(o_mode) != 2'h1 && o_mode != 2'h1 |-> o_cts)
        else $error("Clear to send low outside handshake mode.");
    cts_block_a: assert property (o_mode == 2'h1 && $past(o_mode) == 2'h1
        && (i_buf_low || i_remote_fc[o_cur_sess]) |=> !o_cts) else $error("CTS not dropped.");
    cts_grant_a: assert property (o_mode == 2'h1 && $past(o_mode) == 2'h1
        && !i_buf_low && !i_remote_fc[o_cur_sess] |=> o_cts) else $error("CTS not raised.");
    halt_out_a: assert property (o_out_halt |-> o_sess_out_en == '0 && !o_tx_ready)
        else $error("Output still enabled while halted.");
    none_fwd_a: assert property (o_mode != 2'h2 && i_rx_valid
        |=> o_fwd_valid && o_fwd_data == $past(i_rx_data)) else $error("Character lost.");
    pause_eat_a: assert property (o_mode == 2'h2 && i_rx_valid && i_rx_data == pause_r
        |=> !o_fwd_valid) else $error("Pause character forwarded.");
    sess_switch_a: assert property (i_switch && int'(i_switch_sess) < SESS
        |=> o_cur_sess == $past(i_switch_sess)) else $error("Switch not taken.");
    susp_set_a: assert property ((i_suspend && !i_switch) ##1 !i_switch |=>
        (o_sess_throttle & $past(i_suspend_mask, 2) & ~(SESS'(1) << o_cur_sess))
        == ($past(i_suspend_mask, 2) & ~(SESS'(1) << o_cur_sess))) else $error("Not suspended.");
    unsusp_a: assert property ((i_switch && !i_suspend) ##1 (!i_switch && !i_suspend)
        ##1 !o_out_halt |-> !o_sess_throttle[o_cur_sess]) else $error("Suspend not cleared.");
    cover property (i_switch ##2 o_cur_sess == 2'h2);
    cover property (o_mode == 2'h2 && o_out_halt);
    cover property (o_mode == 2'h1 && !o_cts);
endmodule

bind spfc_port spfc_port_props #(.SESS(SESS), .SW(SW)) u_props (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cfg_wr(i_cfg_wr), .i_cfg_pause(i_cfg_pause),
    .i_suspend(i_suspend), .i_suspend_mask(i_suspend_mask), .i_switch(i_switch),
    .i_switch_sess(i_switch_sess), .i_buf_low(i_buf_low), .i_remote_fc(i_remote_fc),
    .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .o_fwd_valid(o_fwd_valid),
    .o_fwd_data(o_fwd_data), .o_tx_ready(o_tx_ready), .o_cts(o_cts), .o_mode(o_mode),
    .o_out_halt(o_out_halt), .o_sess_throttle(o_sess_throttle),
    .o_sess_out_en(o_sess_out_en), .o_cur_sess(o_cur_sess));

/* tb/spfc_term.sv */
// Behavioural user terminal on the serial side of one port.
// Assumes characters are handed over on valid and ready at the rising edge.
module spfc_term (
    input  wire logic       i_mclk,
    input  wire logic       i_stall,
    input  wire logic       i_hold_out,
    input  wire logic       i_ser_valid,
    input  wire logic [7:0] i_ser_data,
    output logic            o_ser_ready = 1'b0,
    output logic            o_rts = 1'b1,
    output logic [7:0]      o_last = 8'h00,
    output int              o_count = 0
);
    timeunit 1ns;
    timeprecision 100ps;
    // ************************************************************
    // Terminal
    // ************************************************************
    // Lines move after the falling edge, so the port never sees them change at its edge.
    always @(negedge i_mclk)
    begin
        o_ser_ready <= !i_stall;
        o_rts       <= !i_hold_out;
    end
    // A character counts as received only where both sides agree at the edge.
    always @(posedge i_mclk)
    begin
        if (i_ser_valid && o_ser_ready)
        begin
            o_last  <= i_ser_data;
            o_count <= o_count + 1;
        end
    end
endmodule

/* tb/spfc_port_tb.sv */
// Self-checking bench for spfc_port with a behavioural terminal on the serial side.
// Assumes the design files and the checker are compiled first.
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end

module spfc_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SESS = 4;
    localparam int SW   = 2;
    logic            i_mclk, i_rst_n, i_cfg_wr, i_suspend, i_switch, i_buf_low, i_rts;
    logic            i_rx_valid, i_tx_valid, i_ser_ready, o_cts, o_fwd_valid, o_tx_ready;
    logic            o_ser_valid, o_out_halt, stall, hold_out;
    logic [1:0]      i_cfg_mode, o_mode, i_switch_sess, o_cur_sess;
    logic [7:0]      i_cfg_resume, i_cfg_pause, i_rx_data, o_fwd_data, i_tx_data;
    logic [7:0]      o_ser_data, t_last;
    logic [SESS-1:0] i_suspend_mask, i_remote_fc, o_sess_throttle, o_sess_out_en;
    int              n_mismatch, samples_checked, t_count, cycles = 0;

    // ************************************************************
    // Harness
    // ************************************************************
    spfc_port #(.SESS(SESS), .SW(SW)) uut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cfg_wr(i_cfg_wr), .i_cfg_mode(i_cfg_mode),
        .i_cfg_resume(i_cfg_resume), .i_cfg_pause(i_cfg_pause), .i_suspend(i_suspend),
        .i_suspend_mask(i_suspend_mask), .i_switch(i_switch), .i_switch_sess(i_switch_sess),
        .i_buf_low(i_buf_low), .i_remote_fc(i_remote_fc), .i_rts(i_rts), .o_cts(o_cts),
        .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .o_fwd_valid(o_fwd_valid),
        .o_fwd_data(o_fwd_data), .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data),
        .o_tx_ready(o_tx_ready), .o_ser_valid(o_ser_valid), .o_ser_data(o_ser_data),
        .i_ser_ready(i_ser_ready), .o_mode(o_mode), .o_out_halt(o_out_halt),
        .o_sess_throttle(o_sess_throttle), .o_sess_out_en(o_sess_out_en),
        .o_cur_sess(o_cur_sess));
    spfc_term term (.i_mclk(i_mclk), .i_stall(stall), .i_hold_out(hold_out),
        .i_ser_valid(o_ser_valid), .i_ser_data(o_ser_data), .o_ser_ready(i_ser_ready),
        .o_rts(i_rts), .o_last(t_last), .o_count(t_count));

    // 40 MHz clock; the cycle ceiling is far above the hundred or so cycles the tests need.
    always #12.5 i_mclk = ~i_mclk;
    always @(posedge i_mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic tick(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    task automatic cfg(input logic [1:0] md, input logic [7:0] res, input logic [7:0] pau);
        i_cfg_wr = 1;
        i_cfg_mode = md;
        i_cfg_resume = res;
        i_cfg_pause = pau;
        tick(1);
        i_cfg_wr = 0;
        `CHK("mode", md, o_mode)
    endtask
    // The idle cycle at the end keeps two pulses from meeting in one time step.
    task automatic rx(input logic [7:0] d, input logic fwd);
        i_rx_valid = 1;
        i_rx_data = d;
        tick(1);
        i_rx_valid = 0;
        `CHK("fwd_valid", fwd, o_fwd_valid)
        if (fwd)
            `CHK("fwd_data", d, o_fwd_data)
        tick(1);
    endtask
    task automatic tx(input logic [7:0] d);
        for (int k = 0; k < 40 && o_tx_ready !== 1'b1; k++)
            tick(1);
        i_tx_valid = 1;
        i_tx_data = d;
        tick(1);
        i_tx_valid = 0;
    endtask
    task automatic expect_char(input logic [7:0] d);
        int c0;
        c0 = t_count;
        for (int k = 0; k < 40 && t_count == c0; k++)
            tick(1);
        `CHK("char count", c0 + 1, t_count)
        `CHK("char", d, t_last)
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_none();
        `CHK("reset cts", 1'b1, o_cts)
        `CHK("reset cur", 2'h0, o_cur_sess)
        `CHK("reset mode", 2'h0, o_mode)
        i_buf_low = 1;
        hold_out = 1;
        tick(5);
        `CHK("cts", 1'b1, o_cts)
        `CHK("halt", 1'b0, o_out_halt)
        rx(8'h13, 1);
        stall = 1;
        tx(8'h3C);
        tick(3);
        `CHK("held data", 8'h3C, o_ser_data)
        stall = 0;
        expect_char(8'h3C);
        i_buf_low = 0;
        hold_out = 0;
        $display("Test no flow control done");
    endtask
    task automatic t_hw();
        cfg(2'h1, 8'h11, 8'h13);
        i_buf_low = 1;
        tick(2);
        `CHK("cts buffers", 1'b0, o_cts)
        i_buf_low = 0;
        i_remote_fc = 4'h2;
        tick(2);
        `CHK("cts other", 1'b1, o_cts)
        i_remote_fc = 4'h1;
        tick(2);
        `CHK("cts remote", 1'b0, o_cts)
        i_remote_fc = 4'h0;
        hold_out = 1;
        tick(6);
        `CHK("cts credit", 1'b1, o_cts)
        `CHK("halt", 1'b1, o_out_halt)
        `CHK("throttle", 4'h1, o_sess_throttle)
        hold_out = 0;
        tick(6);
        `CHK("halt off", 1'b0, o_out_halt)
        $display("Test handshake done");
    endtask
    task automatic t_sw();
        cfg(2'h2, 8'h11, 8'h13);
        rx(8'h11, 1);
        rx(8'h13, 0);
        rx(8'h13, 0);
        `CHK("paused", 1'b1, o_out_halt)
        `CHK("tx_ready", 1'b0, o_tx_ready)
        rx(8'h11, 0);
        tick(1);
        `CHK("resumed", 1'b0, o_out_halt)
        cfg(2'h2, 8'h5A, 8'hA5);
        rx(8'h13, 1);
        rx(8'hA5, 0);
        rx(8'h5A, 0);
        i_buf_low = 1;
        expect_char(8'hA5);
        `CHK("sw cts", 1'b1, o_cts)
        rx(8'h41, 0);
        i_buf_low = 0;
        expect_char(8'h5A);
        tick(2);
        rx(8'h42, 1);
        i_remote_fc = 4'h1;
        expect_char(8'hA5);
        i_remote_fc = 4'h0;
        expect_char(8'h5A);
        $display("Test software flow done");
    endtask
    task automatic t_sess();
        cfg(2'h1, 8'h11, 8'h13);
        i_suspend = 1;
        i_suspend_mask = 4'hF;
        tick(1);
        i_suspend = 0;
        i_remote_fc = 4'h4;
        tick(2);
        `CHK("suspended", 4'hE, o_sess_throttle)
        `CHK("out_en", 4'h1, o_sess_out_en)
        i_switch = 1;
        i_switch_sess = 2'h2;
        tick(1);
        i_switch = 0;
        tick(2);
        `CHK("current", 2'h2, o_cur_sess)
        `CHK("unsuspended", 4'hA, o_sess_throttle)
        `CHK("cts remote", 1'b0, o_cts)
        $display("Test sessions done");
    endtask

    initial
    begin
        {i_mclk, i_rst_n, i_cfg_wr, i_suspend, i_switch, i_buf_low} = '0;
        {i_rx_valid, i_tx_valid, stall, hold_out, i_cfg_mode, i_switch_sess} = '0;
        {i_cfg_resume, i_cfg_pause, i_rx_data, i_tx_data} = '0;
        {i_suspend_mask, i_remote_fc} = '0;
        {n_mismatch, samples_checked} = '0;
        tick(12);
        i_rst_n = 1;
        tick(1);
        t_none();
        t_hw();
        t_sw();
        t_sess();
        report_and_stop();
    end
endmodule
